// ### fault_protect_cfg.svh
// Address map, reset values and timing counts of the fault-protection block.
`ifndef FAULT_PROTECT_CFG_SVH
`define FAULT_PROTECT_CFG_SVH

`define ADDR_CTRL       8'h00
`define ADDR_CMD        8'h04
`define ADDR_STATUS     8'h08

`define CTRL_RESET      32'hFFFF_0000
`define CMD_CLEAR_BIT   0

`define CLK_PERIOD_NS   100
`define CLK_MHZ         10

// Overcurrent filter choices in nanoseconds; a least time rounds up.
`define FILTER0_NS      200
`define FILTER1_NS      500
`define FILTER2_NS      1000
`define FILTER3_NS      1600
`define NS_TO_CYC(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Automatic retry choices in microseconds.
`define RETRY_SHORT_US  5000
`define RETRY_LONG_US   500000

`endif

// ### fault_protect_pkg.sv
// Types shared by the fault-protection block.
package fault_protect_pkg;

  typedef enum logic [1:0] {
    OC_LATCHED = 2'b00,
    OC_RETRY   = 2'b01,
    OC_REPORT  = 2'b10,
    OC_OFF     = 2'b11
  } oc_policy_t;

  typedef enum logic [1:0] {
    OCS_RUN   = 2'b00,
    OCS_LATCH = 2'b01,
    OCS_WAIT  = 2'b10
  } oc_state_t;

  typedef enum logic [0:0] {
    PCS_IDLE = 1'b0,
    PCS_HOLD = 1'b1
  } pcl_state_t;

  typedef struct packed {
    logic [7:0] open_loop_limit_setting;
    logic [7:0] closed_loop_threshold;
    logic [3:0] per_cycle_limit_wait_count;
    logic [3:0] per_cycle_limit_policy;
    logic       spare;
    logic       supply_high_level_pick;
    logic       supply_high_guard_on;
    logic       fet_overcurrent_retry_time;
    logic [1:0] fet_overcurrent_filter_time;
    oc_policy_t fet_overcurrent_policy;
  } ctrl_cfg_t;

  typedef struct packed {
    logic [17:0] spare;
    logic        recirculating;
    logic        fets_disabled;
    logic [5:0]  per_fet_overcurrent;
    logic        per_cycle_limit;
    logic        control_error;
    logic        fet_overcurrent_flag;
    logic        supply_high_flag;
    logic        pump_low_flag;
    logic        gate_stage_error;
  } status_t;

  typedef struct packed {
    logic       main_supply_low;
    logic       analog_rail_low;
    logic       switcher_rail_low;
    logic       buck_overcurrent;
    logic       pump_rail_low;
    logic       supply_above_low_level;
    logic       supply_above_high_level;
    logic [5:0] fet_over_level;
    logic       limit_trip;
  } sense_t;

endpackage

// ### fault_protect.sv
// Fault detection, output-stage action, sticky flags and fault pin for the motor driver.
//
// Summary of operation
// - Main supply low: FETs and pump off, full reset.
// - Analog rail low: FETs and pump off, full reset.
// - Switcher rail low: buck off, full reset.
// - Filtered buck overcurrent forces full reset.
// - Pump low: FETs off, pin low, flags.
// - Guarded supply high: FETs off, pin, flags.
// - Supply high level picks one of two.
// - FET overcurrent filtered, acted on per policy.
// - Latched policy: off until clear command.
// - Retry policy: off for retry time.
// - Report policy: flags only, keep driving.
// - Disabled policy: ignore FET overcurrent.
// - Limit threshold from closed or open setting.
// - Limit event: recirculate, set limit flag.
// - Next-cycle mode resumes at next PWM.
// - Mode 0000b adds error and pin.
// - Threshold mode resumes when sense drops.
// - Count mode resumes after wait+1 cycles.
// - Limit report mode: flags, keep driving.
// - Modes 0111b and 1xxxb ignore limit.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "fault_protect_cfg.svh"

module fault_protect #(
  parameter int unsigned RETRY_SHORT_CYCLES = `RETRY_SHORT_US * `CLK_MHZ,
  parameter int unsigned RETRY_LONG_CYCLES  = `RETRY_LONG_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Analog comparator pins
  input  wire logic        main_supply_low_in,
  input  wire logic        analog_rail_low_in,
  input  wire logic        switcher_rail_low_in,
  input  wire logic        buck_overcurrent_in,
  input  wire logic        pump_rail_low_in,
  input  wire logic        supply_above_low_level_in,
  input  wire logic        supply_above_high_level_in,
  input  wire logic [5:0]  fet_over_level_in,
  input  wire logic        limit_trip_in,
  // PWM timing from the commutation logic
  input  wire logic        pwm_cycle_start_in,
  input  wire logic        closed_loop_in,
  // Power stage and system actions
  output logic             fets_off_out,
  output logic             recirculate_out,
  output logic             pump_off_out,
  output logic             buck_off_out,
  output logic             system_reset_out,
  output logic [7:0]       limit_threshold_out,
  output logic [1:0]       fet_overcurrent_level_out,
  output logic             fault_indicator_pin_n_out
);

  fault_protect_pkg::sense_t  sense_async;
  fault_protect_pkg::sense_t  sync1_r;
  fault_protect_pkg::sense_t  sense_r;
  fault_protect_pkg::ctrl_cfg_t ctrl_r;
  fault_protect_pkg::status_t status;
  fault_protect_pkg::oc_state_t  oc_state_r;
  fault_protect_pkg::oc_state_t  oc_state_nxt;
  fault_protect_pkg::pcl_state_t pcl_state_r;
  fault_protect_pkg::pcl_state_t pcl_state_nxt;

  logic [4:0]  filter_cycles;
  logic [5:0]  fet_event;
  logic [5:0]  per_fet_r;
  logic [4:0]  buck_cnt_r;
  logic        buck_event;
  logic        supply_reset;
  logic        clear_cmd;
  logic        pump_low_r;
  logic        supply_high_r;
  logic        fet_oc_r;
  logic        gate_err_r;
  logic        pcl_report_r;
  logic        supply_high_live;
  logic        driver_live;
  logic        oc_event;
  logic        oc_raw_any;
  logic        oc_acting;
  logic [22:0] retry_cnt_r;
  logic [22:0] retry_load;
  logic [4:0]  pwm_cnt_r;
  logic [3:0]  pol;
  logic        pcl_ignored;
  logic        pcl_report_mode;
  logic        pcl_recover_mode;
  logic        pcl_release;
  logic        pcl_quiet;
  logic        fault_pin_req;

  // Every comparator output crosses into the clock domain through two flops.
  assign sense_async = '{main_supply_low: main_supply_low_in, analog_rail_low: analog_rail_low_in,
                         switcher_rail_low: switcher_rail_low_in, buck_overcurrent: buck_overcurrent_in,
                         pump_rail_low: pump_rail_low_in, supply_above_low_level: supply_above_low_level_in,
                         supply_above_high_level: supply_above_high_level_in,
                         fet_over_level: fet_over_level_in, limit_trip: limit_trip_in};

  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      sync1_r <= '0;
      sense_r <= '0;
    end
    else
    begin
      sync1_r <= sense_async;
      sense_r <= sync1_r;
    end

  // Register decode.
  wire wr_ctrl = wr_in && (addr_in == `ADDR_CTRL);
  wire wr_cmd  = wr_in && (addr_in == `ADDR_CMD);
  assign clear_cmd = wr_cmd && wdata_in[`CMD_CLEAR_BIT];

  wire [31:0] rdata_nxt = !rd_in                    ? 32'h0000_0000 :
                          (addr_in == `ADDR_CTRL)   ? ctrl_r :
                          (addr_in == `ADDR_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      ctrl_r    <= `CTRL_RESET;
      rdata_out <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wdata_in;
      rdata_out <= rdata_nxt;
    end

  // Filter length follows the configured filter time.
  assign filter_cycles = (ctrl_r.fet_overcurrent_filter_time == 2'b00) ? 5'(`NS_TO_CYC(`FILTER0_NS)) :
                         (ctrl_r.fet_overcurrent_filter_time == 2'b01) ? 5'(`NS_TO_CYC(`FILTER1_NS)) :
                         (ctrl_r.fet_overcurrent_filter_time == 2'b10) ? 5'(`NS_TO_CYC(`FILTER2_NS)) :
                                                                         5'(`NS_TO_CYC(`FILTER3_NS));

  // Supply-level faults drop the whole device into reset.
  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
      buck_cnt_r <= 5'h00;
    else if (!sense_r.buck_overcurrent)
      buck_cnt_r <= 5'h00;
    else if (buck_cnt_r != filter_cycles)
      buck_cnt_r <= buck_cnt_r + 5'h01;

  assign buck_event   = sense_r.buck_overcurrent && (buck_cnt_r == filter_cycles);
  assign supply_reset = sense_r.main_supply_low
                      | sense_r.analog_rail_low
                      | sense_r.switcher_rail_low
                      | buck_event;

  // Per-FET filters: an event needs the full filter time above level.
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : fet_filter
      logic [4:0] cnt_r;
      always_ff @(posedge clock_in or negedge arst_n_in)
        if (!arst_n_in)
          cnt_r <= 5'h00;
        else if (!sense_r.fet_over_level[g] || supply_reset)
          cnt_r <= 5'h00;
        else if (cnt_r != filter_cycles)
          cnt_r <= cnt_r + 5'h01;
      assign fet_event[g] = sense_r.fet_over_level[g] && (cnt_r == filter_cycles);
    end
  endgenerate

  assign oc_raw_any = |sense_r.fet_over_level;
  assign oc_acting  = ctrl_r.fet_overcurrent_policy != fault_protect_pkg::OC_OFF;
  assign oc_event   = (|fet_event) && oc_acting;

  // FET overcurrent response.
  assign retry_load = ctrl_r.fet_overcurrent_retry_time ? 23'(RETRY_LONG_CYCLES) : 23'(RETRY_SHORT_CYCLES);

  always_comb
  begin
    oc_state_nxt = oc_state_r;
    case (oc_state_r)
      fault_protect_pkg::OCS_RUN:
        if (oc_event && ctrl_r.fet_overcurrent_policy == fault_protect_pkg::OC_LATCHED)
          oc_state_nxt = fault_protect_pkg::OCS_LATCH;
        else if (oc_event && ctrl_r.fet_overcurrent_policy == fault_protect_pkg::OC_RETRY)
          oc_state_nxt = fault_protect_pkg::OCS_WAIT;
      fault_protect_pkg::OCS_LATCH:
        if (clear_cmd && !oc_raw_any)
          oc_state_nxt = fault_protect_pkg::OCS_RUN;
      fault_protect_pkg::OCS_WAIT:
        if (retry_cnt_r == 23'h000001)
          oc_state_nxt = fault_protect_pkg::OCS_RUN;
      default:
        oc_state_nxt = fault_protect_pkg::OCS_RUN;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      oc_state_r  <= fault_protect_pkg::OCS_RUN;
      retry_cnt_r <= 23'h000000;
    end
    else if (supply_reset)
    begin
      oc_state_r  <= fault_protect_pkg::OCS_RUN;
      retry_cnt_r <= 23'h000000;
    end
    else
    begin
      oc_state_r  <= oc_state_nxt;
      retry_cnt_r <= (oc_state_r != fault_protect_pkg::OCS_WAIT) ? retry_load : retry_cnt_r - 23'h000001;
    end

  // Per-cycle limit response.
  assign pol              = ctrl_r.per_cycle_limit_policy;
  assign pcl_ignored      = pol[3] || (pol == 4'h7);
  assign pcl_report_mode  = (pol == 4'h6);
  assign pcl_recover_mode = !pcl_ignored && !pcl_report_mode;
  assign pcl_quiet        = pol[0];
  assign pcl_release      = (pol[2:1] == 2'b00) ? pwm_cycle_start_in :
                            (pol[2:1] == 2'b01) ? !sense_r.limit_trip :
                            (pwm_cycle_start_in && pwm_cnt_r == {1'b0, ctrl_r.per_cycle_limit_wait_count});

  always_comb
  begin
    pcl_state_nxt = pcl_state_r;
    case (pcl_state_r)
      fault_protect_pkg::PCS_IDLE:
        if (sense_r.limit_trip && pcl_recover_mode)
          pcl_state_nxt = fault_protect_pkg::PCS_HOLD;
      fault_protect_pkg::PCS_HOLD:
        if (!pcl_recover_mode || pcl_release)
          pcl_state_nxt = fault_protect_pkg::PCS_IDLE;
      default:
        pcl_state_nxt = fault_protect_pkg::PCS_IDLE;
    endcase
  end

  // The cycle counter counts PWM starts seen while held; release on the (wait+1)th.
  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      pcl_state_r <= fault_protect_pkg::PCS_IDLE;
      pwm_cnt_r   <= 5'h00;
    end
    else if (supply_reset)
    begin
      pcl_state_r <= fault_protect_pkg::PCS_IDLE;
      pwm_cnt_r   <= 5'h00;
    end
    else
    begin
      pcl_state_r <= pcl_state_nxt;
      if (pcl_state_r == fault_protect_pkg::PCS_IDLE)
        pwm_cnt_r <= 5'h00;
      else if (pwm_cycle_start_in)
        pwm_cnt_r <= pwm_cnt_r + 5'h01;
    end

  wire pcl_hold = (pcl_state_r == fault_protect_pkg::PCS_HOLD);

  // Sticky flags: a set in the same cycle as a clear wins.
  assign supply_high_live = ctrl_r.supply_high_guard_on &&
                            (ctrl_r.supply_high_level_pick ? sense_r.supply_above_high_level
                                                           : sense_r.supply_above_low_level);
  assign driver_live = sense_r.pump_rail_low || supply_high_live || oc_raw_any;

  wire pump_set = sense_r.pump_rail_low;
  wire oc_flag_set = oc_event && (ctrl_r.fet_overcurrent_policy != fault_protect_pkg::OC_OFF);
  wire pcl_rep_set = sense_r.limit_trip && pcl_report_mode;

  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      pump_low_r    <= 1'b0;
      supply_high_r <= 1'b0;
      fet_oc_r      <= 1'b0;
      per_fet_r     <= 6'h00;
      gate_err_r    <= 1'b0;
      pcl_report_r  <= 1'b0;
    end
    else if (supply_reset)
    begin
      pump_low_r    <= 1'b0;
      supply_high_r <= 1'b0;
      fet_oc_r      <= 1'b0;
      per_fet_r     <= 6'h00;
      gate_err_r    <= 1'b0;
      pcl_report_r  <= 1'b0;
    end
    else
    begin
      pump_low_r    <= pump_set || (pump_low_r && !clear_cmd);
      supply_high_r <= supply_high_live || (supply_high_r && !clear_cmd);
      fet_oc_r      <= oc_flag_set || (fet_oc_r && !(clear_cmd && !oc_raw_any));
      per_fet_r     <= (oc_flag_set ? fet_event : 6'h00) | (per_fet_r & {6{!(clear_cmd && !oc_raw_any)}});
      gate_err_r    <= pump_set || supply_high_live || oc_flag_set ||
                       (gate_err_r && !(clear_cmd && !driver_live));
      pcl_report_r  <= pcl_rep_set || (pcl_report_r && !(clear_cmd && !sense_r.limit_trip));
    end

  assign status = '{spare: 18'h00000, recirculating: recirculate_out, fets_disabled: fets_off_out,
                    per_fet_overcurrent: per_fet_r, per_cycle_limit: pcl_hold || pcl_report_r,
                    control_error: (pcl_hold && !pcl_quiet) || pcl_report_r,
                    fet_overcurrent_flag: fet_oc_r, supply_high_flag: supply_high_r,
                    pump_low_flag: pump_low_r, gate_stage_error: gate_err_r};

  // Report-only faults never reach the pin.
  assign fault_pin_req = sense_r.pump_rail_low || supply_high_live ||
                         (oc_state_r != fault_protect_pkg::OCS_RUN) ||
                         (pcl_hold && !pcl_quiet);

  // The threshold goes out to the analog comparator.
  wire [7:0] thresh_nxt = closed_loop_in ? ctrl_r.closed_loop_threshold
                                         : ctrl_r.open_loop_limit_setting;

  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      fets_off_out              <= 1'b1;
      recirculate_out           <= 1'b0;
      pump_off_out              <= 1'b1;
      buck_off_out              <= 1'b0;
      system_reset_out          <= 1'b1;
      limit_threshold_out       <= 8'h00;
      fet_overcurrent_level_out <= 2'b00;
      fault_indicator_pin_n_out <= 1'b1;
    end
    else
    begin
      fets_off_out              <= supply_reset || sense_r.pump_rail_low || supply_high_live ||
                                   (oc_state_nxt != fault_protect_pkg::OCS_RUN);
      recirculate_out           <= !supply_reset && (pcl_state_nxt == fault_protect_pkg::PCS_HOLD);
      pump_off_out              <= sense_r.main_supply_low || sense_r.analog_rail_low;
      buck_off_out              <= sense_r.switcher_rail_low;
      system_reset_out          <= supply_reset;
      limit_threshold_out       <= thresh_nxt;
      fet_overcurrent_level_out <= ctrl_r.spare ? 2'b11 : 2'b00;
      fault_indicator_pin_n_out <= !(fault_pin_req && !supply_reset);
    end

endmodule // fault_protect

// ### fault_protect_assertions.sv
// Port-level assertions for the fault-protection block, bound to its top module.
`timescale 1ns/10ps
module fault_protect_checker (
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        arst_n_in,
  // Register port
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  // Comparators
  input wire logic        main_supply_low_in,
  input wire logic        analog_rail_low_in,
  input wire logic        switcher_rail_low_in,
  input wire logic        pump_rail_low_in,
  input wire logic        supply_above_low_level_in,
  input wire logic        supply_above_high_level_in,
  input wire logic        limit_trip_in,
  // Actions
  input wire logic        fets_off_out,
  input wire logic        recirculate_out,
  input wire logic        pump_off_out,
  input wire logic        buck_off_out,
  input wire logic        system_reset_out,
  input wire logic        fault_indicator_pin_n_out
);
  fault_protect_pkg::ctrl_cfg_t cfg_r;
  logic [3:0]                   pol;
  logic                         ov_now;
  // The checker sees only ports, so it keeps its own copy of the control word.
  assign pol = cfg_r.per_cycle_limit_policy;
  assign ov_now = cfg_r.supply_high_guard_on &&
                  (cfg_r.supply_high_level_pick ? supply_above_high_level_in : supply_above_low_level_in);
  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
      cfg_r <= fault_protect_pkg::ctrl_cfg_t'(32'hFFFF_0000);
    else if (wr_in && addr_in == 8'h00)
      cfg_r <= fault_protect_pkg::ctrl_cfg_t'(wdata_in);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  property p_main_low;
    main_supply_low_in |-> ##[1:4] (system_reset_out && fets_off_out && pump_off_out);
  endproperty
  a_main_low: assert property (p_main_low) else $error("main supply low not acted on");
  property p_analog_low;
    analog_rail_low_in |-> ##[1:4] (system_reset_out && fets_off_out && pump_off_out);
  endproperty
  a_analog_low: assert property (p_analog_low) else $error("analog rail low not acted on");
  property p_switcher_low;
    switcher_rail_low_in |-> ##[1:4] (system_reset_out && buck_off_out);
  endproperty
  a_switcher_low: assert property (p_switcher_low) else $error("switcher rail low not acted on");
  property p_pump_low;
    pump_rail_low_in |-> ##[1:4] (fets_off_out && !fault_indicator_pin_n_out);
  endproperty
  a_pump_low: assert property (p_pump_low) else $error("pump rail low not acted on");
  property p_supply_high;
    ov_now |-> ##[1:4] (fets_off_out && !fault_indicator_pin_n_out);
  endproperty
  a_supply_high: assert property (p_supply_high) else $error("supply high not acted on");
  property p_limit_hold;
    (pol[3:1] == 3'b001 && limit_trip_in) [*3] |-> ##[0:2] recirculate_out;
  endproperty
  a_limit_hold: assert property (p_limit_hold) else $error("limit event not recirculating");
  property p_limit_loud;
    (recirculate_out && (pol == 4'h0 || pol == 4'h2 || pol == 4'h4)) |-> ##[0:1] !fault_indicator_pin_n_out;
  endproperty
  a_limit_loud: assert property (p_limit_loud) else $error("limit hold without fault pin");
  property p_limit_ignored;
    (pol[3] || pol == 4'h7) [*4] |-> !recirculate_out;
  endproperty
  a_limit_ignored: assert property (p_limit_ignored) else $error("ignored limit still acted");
  property p_rdata_idle;
    (!rd_in || addr_in == 8'h04) |=> rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
endmodule // fault_protect_checker

bind fault_protect fault_protect_checker fault_protect_checker_inst (
  .clock_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .main_supply_low_in, .analog_rail_low_in, .switcher_rail_low_in, .pump_rail_low_in,
  .supply_above_low_level_in, .supply_above_high_level_in, .limit_trip_in, .fets_off_out,
  .recirculate_out, .pump_off_out, .buck_off_out, .system_reset_out, .fault_indicator_pin_n_out);

// ### analog_front_model.sv
// Behavioural model of the comparators and PWM timer around the block.
`timescale 1ns/10ps
module analog_front_model #(
  parameter int PWM_PERIOD = 10
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  // Supply and sense levels set by the bench, limit threshold set by the block
  input  wire logic [7:0] supply_volts_in,
  input  wire logic [7:0] sense_level_in,
  input  wire logic [7:0] limit_threshold_in,
  // Comparator and timer outputs
  output logic            above_low_out,
  output logic            above_high_out,
  output logic            limit_trip_out,
  output logic            pwm_start_out
);
  logic [7:0] pwm_cnt_r;
  // Comparator outputs are raw levels that may move at any time; the block must synchronise them.
  assign above_low_out  = supply_volts_in > 8'h14;
  assign above_high_out = supply_volts_in > 8'h20;
  assign limit_trip_out = sense_level_in > limit_threshold_in;
  always_ff @(posedge clock_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      pwm_cnt_r     <= 8'h00;
      pwm_start_out <= 1'b0;
    end
    else
    begin
      pwm_cnt_r     <= (pwm_cnt_r == PWM_PERIOD - 1) ? 8'h00 : pwm_cnt_r + 8'h01;
      pwm_start_out <= pwm_cnt_r == PWM_PERIOD - 1;
    end
endmodule // analog_front_model

// ### fault_protect_bench.sv
// Self-checking bench for the fault-protection block.
`timescale 1ns/10ps
module fault_protect_bench;
  logic        clock_in, arst_n_in, wr_in, rd_in, pump_low, closed_loop;
  logic [7:0]  addr_in, volts, sense, thr;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0]  sup;
  logic [5:0]  fet_over;
  logic        above_lo, above_hi, trip, pwm_start;
  logic        fets_off, recirc, pump_off, buck_off, sys_rst, pin_n;
  logic [1:0]  oc_lvl;
  int          n_fail, total_checks;

  fault_protect #(.RETRY_SHORT_CYCLES(20), .RETRY_LONG_CYCLES(40)) fault_protect_inst (
    .clock_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .main_supply_low_in(sup[0]), .analog_rail_low_in(sup[1]), .switcher_rail_low_in(sup[2]),
    .buck_overcurrent_in(sup[3]), .pump_rail_low_in(pump_low), .supply_above_low_level_in(above_lo),
    .supply_above_high_level_in(above_hi), .fet_over_level_in(fet_over), .limit_trip_in(trip),
    .pwm_cycle_start_in(pwm_start), .closed_loop_in(closed_loop), .fets_off_out(fets_off),
    .recirculate_out(recirc), .pump_off_out(pump_off), .buck_off_out(buck_off),
    .system_reset_out(sys_rst), .limit_threshold_out(thr), .fet_overcurrent_level_out(oc_lvl),
    .fault_indicator_pin_n_out(pin_n));
  analog_front_model analog_front_model_inst (
    .clock_in, .arst_n_in, .supply_volts_in(volts), .sense_level_in(sense),
    .limit_threshold_in(thr), .above_low_out(above_lo), .above_high_out(above_hi),
    .limit_trip_out(trip), .pwm_start_out(pwm_start));

  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic seen, input logic exp);
    chk(what, {31'h0, seen}, {31'h0, exp});
  endtask
  // Sampling 1 ns after the edge lets that edge's register updates land first.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic s_regs;
    logic [31:0] v;
    rd(8'h00, v);
    chk("ctrl reset", v, 32'hFFFF_0000);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, v);
    chk("unmapped", v, 32'h0);
    rd(8'h04, v);
    chk("cmd read", v, 32'h0);
    wr(8'h00, 32'h3C5A_0080);
    rd(8'h00, v);
    chk("ctrl", v, 32'h3C5A_0080);
    chk("oc level", {30'h0, oc_lvl}, 32'h3);
    chk("closed thr", {24'h0, thr}, 32'h5A);
    @(posedge clock_in);
    closed_loop <= 1'b0;
    cyc(3);
    chk("open thr", {24'h0, thr}, 32'h3C);
  endtask
  task automatic s_supply;
    wr(8'h00, 32'h0000_000C);
    @(posedge clock_in);
    sup <= 4'h8;
    cyc(8);
    sup <= 4'h0;
    cyc(4);
    chk1("buck glitch", sys_rst, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      sup <= 4'h1 << i;
      cyc(24);
      chk1("reset", sys_rst, 1'b1);
      chk1("pump off", pump_off, i < 2);
      chk1("buck off", buck_off, i == 2);
      if (i < 2)
        chk1("fets off", fets_off, 1'b1);
      sup <= 4'h0;
      cyc(6);
      chk1("reset end", sys_rst, 1'b0);
    end
  endtask
  task automatic s_pump;
    logic [31:0] v;
    pump_low <= 1'b1;
    cyc(5);
    chk1("pump fets", fets_off, 1'b1);
    chk1("pump pin", pin_n, 1'b0);
    wr(8'h04, 32'h1);
    rd(8'h08, v);
    chk("pump flags", v & 32'h3, 32'h3);
    pump_low <= 1'b0;
    cyc(5);
    chk1("pump resume", fets_off, 1'b0);
    chk1("pump pin free", pin_n, 1'b1);
    rd(8'h08, v);
    chk("pump sticky", v & 32'h2, 32'h2);
    wr(8'h04, 32'h1);
    rd(8'h08, v);
    chk("pump clear", v, 32'h0);
  endtask
  task automatic s_ovp;
    logic [31:0] v;
    logic [7:0]  lvl [4] = '{8'h18, 8'h18, 8'h24, 8'h24};
    logic [1:0]  ctl [4] = '{2'b01, 2'b11, 2'b11, 2'b10};
    logic        exp;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {25'h0, ctl[i], 5'h0});
      volts <= lvl[i];
      exp = ctl[i][0] && (lvl[i] > (ctl[i][1] ? 8'h20 : 8'h14));
      cyc(5);
      chk1("ov fets", fets_off, exp);
      chk1("ov pin", pin_n, !exp);
      volts <= 8'h0C;
      cyc(5);
      chk1("ov resume", fets_off, 1'b0);
      rd(8'h08, v);
      chk("ov flag", v & 32'h4, {29'h0, exp, 2'h0});
      wr(8'h04, 32'h1);
    end
  endtask
  task automatic s_fet_oc;
    logic [31:0] v;
    for (logic [2:0] p = 0; p < 4; p++)
    begin
      wr(8'h04, 32'h1);
      wr(8'h00, {29'h0, p});
      fet_over <= 6'h04;
      @(posedge clock_in);
      fet_over <= 6'h00;
      cyc(5);
      rd(8'h08, v);
      chk("oc glitch", v, 32'h0);
      fet_over <= 6'h04;
      cyc(6);
      chk1("oc fets", fets_off, p < 2);
      chk1("oc pin", pin_n, p >= 2);
      rd(8'h08, v);
      chk("oc flags", v & 32'h11FF, ((p < 3) ? 32'h109 : 32'h0) | {19'h0, p < 2, 12'h0});
      fet_over <= 6'h00;
      cyc(8);
      chk1("oc held", fets_off, p < 2);
      cyc(30);
      chk1("oc retry", fets_off, p == 0);
      rd(8'h08, v);
      chk("oc kept", v & 32'h1FF, (p < 3) ? 32'h109 : 32'h0);
      wr(8'h04, 32'h1);
      cyc(3);
      chk1("oc clear", fets_off, 1'b0);
    end
  endtask
  // Each event is launched on a PWM start so that the next start falls at a known cycle.
  task automatic s_limit;
    logic [31:0] v;
    logic        loud;
    closed_loop <= 1'b1;
    for (logic [3:0] m = 0; m < 9; m++)
    begin
      wr(8'h04, 32'h1);
      wr(8'h00, {8'h00, 8'h40, 4'h1, m, 8'h03});
      loud = m == 0 || m == 2 || m == 4;
      do @(posedge clock_in); while (pwm_start !== 1'b1);
      sense <= 8'h50;
      cyc(4);
      chk1("lim recirc", recirc, m < 6);
      chk1("lim pin", pin_n, !loud);
      rd(8'h08, v);
      chk("lim flags", v & 32'h2030, {18'h0, m < 6, 7'h0, m < 7, loud || m == 6, 4'h0});
      @(posedge clock_in);
      sense <= 8'h00;
      cyc(8);
      chk1("lim count", recirc, m == 4 || m == 5);
      cyc(12);
      chk1("lim free", recirc, 1'b0);
      chk1("lim pin free", pin_n, 1'b1);
      rd(8'h08, v);
      chk("lim report", v & 32'h30, (m == 6) ? 32'h30 : 32'h0);
    end
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial
  begin
    #2000000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    arst_n_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    sup = 4'h0;
    pump_low = 1'b0;
    fet_over = 6'h00;
    closed_loop = 1'b1;
    volts = 8'h0C;
    sense = 8'h00;
    repeat (16) @(posedge clock_in);
    arst_n_in <= 1'b1;
    s_regs();
    s_supply();
    s_pump();
    s_ovp();
    s_fet_oc();
    s_limit();
    end_sim();
  end
endmodule // fault_protect_bench
